// >>> vectored_interrupt_flag_logic.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`include "irq_flag_regs.svh"

module vectored_interrupt_flag_logic
  import irq_flag_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral event pulses
  input  wire logic        clock_timer_evt,
  input  wire logic        stopwatch_evt,
  input  wire logic        serial_evt,
  input  wire logic        prog_timer_evt,
  // Input port pins
  input  wire logic        k_pin0,
  input  wire logic        k_pin1,
  // Processor core
  input  wire logic        global_irq_enable_op,
  input  wire logic        global_irq_disable_op,
  input  wire logic        core_accept,
  input  wire logic        core_vec_fetch,
  output logic             core_irq_req,
  output logic      [11:0] vector_addr,
  output logic             vector_valid,
  // Peripheral control and system interrupt
  output logic             clock_timer_rst,
  output logic             irq
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Vector of the highest set source; OR-ing two results models the
  // address collision seen when a late request overtakes an accepted one
  function automatic pc_addr_t prio_vec(input src_vec_t bits);
    pc_addr_t v;
    v = `VEC_NONE;
    if (bits[`SRC_PTIMER])      v = `VEC_PTIMER;
    else if (bits[`SRC_SERIAL]) v = `VEC_SERIAL;
    else if (bits[`SRC_KPORT1]) v = `VEC_KPORT1;
    else if (bits[`SRC_KPORT0]) v = `VEC_KPORT0;
    else if (bits[`SRC_SWATCH]) v = `VEC_SWATCH;
    else if (bits[`SRC_CTIMER]) v = `VEC_CTIMER;
    return v;
  endfunction : prio_vec

  function automatic src_vec_t prio_onehot(input src_vec_t bits);
    src_vec_t o;
    o = '0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (bits[i]) begin
        o    = '0;
        o[i] = 1'b1;
      end
    end
    return o;
  endfunction : prio_onehot

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  src_vec_t          flag;
  src_vec_t          next_flag;
  src_vec_t          mask;
  src_vec_t          next_mask;
  logic [`CTRL_W-1:0] ctrl;
  logic [`CTRL_W-1:0] next_ctrl;
  logic              gie;
  logic              next_gie;
  logic [31:0]       next_prdata;
  logic              next_ctimer_rst;
  logic [1:0]        kport_q;
  logic [1:0]        next_kport_q;
  vec_state_t        state;
  vec_state_t        next_state;
  src_vec_t          acc_bits;
  src_vec_t          next_acc_bits;
  pc_addr_t          late_vec;
  pc_addr_t          next_late_vec;
  pc_addr_t          next_vector_addr;
  logic              next_vector_valid;

  logic [1:0]        kport_sync;
  logic [1:0]        kport_qual;
  src_vec_t          set_evt;
  src_vec_t          clr_evt;
  src_vec_t          pending;
  src_vec_t          higher;
  logic              setup_ph;
  logic              access_ph;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;

  // --------------------------------------------------------------------
  // Input pin synchronisers
  // --------------------------------------------------------------------
  pin_sync2 #(
    .WIDTH (2)
  ) pin_sync2_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async ({k_pin1, k_pin0}),
    .pin_sync  (kport_sync)
  );

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_ok   = (paddr == `OFS_FLAG) || (paddr == `OFS_MASK) ||
                     (paddr == `OFS_CTRL) || (paddr == `OFS_STAT) ||
                     (paddr == `OFS_VEC);
  assign wr_en     = access_ph && pwrite && addr_ok;
  assign rd_en     = access_ph && !pwrite;
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !addr_ok;

  // --------------------------------------------------------------------
  // Event detection
  // --------------------------------------------------------------------
  // Polarity bit 1 selects the rising edge, so the pin is active high.
  // Gating the active level by the mask before edge detection makes a
  // mask re-enable with the pin held active look like a fresh edge.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      kport_qual[i] = (kport_sync[i] == ctrl[`CTRL_POL0 + i]) &&
                      mask[`SRC_KPORT0 + i];
    end
  end
  assign next_kport_q = kport_qual;

  always_comb begin
    set_evt = '0;
    set_evt[`SRC_CTIMER] = clock_timer_evt ||
                           (wr_en && paddr == `OFS_CTRL &&
                            pwdata[`CTRL_CTRST]);
    set_evt[`SRC_SWATCH] = stopwatch_evt;
    set_evt[`SRC_SERIAL] = serial_evt;
    set_evt[`SRC_PTIMER] = prog_timer_evt;
    set_evt[`SRC_KPORT0] = kport_qual[0] && !kport_q[0];
    set_evt[`SRC_KPORT1] = kport_qual[1] && !kport_q[1];
  end

  // --------------------------------------------------------------------
  // Flags and software registers
  // --------------------------------------------------------------------
  // A read clears only the bits latched into prdata during setup, so
  // an event landing between setup and access is never lost
  always_comb begin
    clr_evt = '0;
    if (rd_en && paddr == `OFS_FLAG) begin
      clr_evt = prdata[`NUM_SRC-1:0];
    end else if (wr_en && paddr == `OFS_FLAG) begin
      clr_evt = pwdata[`NUM_SRC-1:0];
    end
    next_flag = (flag & ~clr_evt) | set_evt;
  end

  always_comb begin
    next_mask       = mask;
    next_ctrl       = ctrl;
    next_ctimer_rst = 1'b0;
    if (wr_en && paddr == `OFS_MASK) begin
      next_mask = pwdata[`NUM_SRC-1:0];
    end
    if (wr_en && paddr == `OFS_CTRL) begin
      next_ctrl       = {1'b0, pwdata[`CTRL_POL1:`CTRL_POL0]};
      next_ctimer_rst = pwdata[`CTRL_CTRST];
    end
  end

  always_comb begin
    next_prdata = prdata;
    if (setup_ph && !pwrite) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        `OFS_FLAG: next_prdata[`NUM_SRC-1:0] = flag;
        `OFS_MASK: next_prdata[`NUM_SRC-1:0] = mask;
        `OFS_CTRL: next_prdata[`CTRL_W-1:0]  = ctrl;
        `OFS_STAT: begin
          next_prdata[`STAT_GIE]  = gie;
          next_prdata[`STAT_REQ]  = core_irq_req;
          next_prdata[`STAT_BUSY] = (state == ST_ACCEPT);
        end
        `OFS_VEC:  next_prdata[11:0] = vector_addr;
        default:   next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Requests to the core
  // --------------------------------------------------------------------
  assign pending      = flag & mask;
  assign irq          = |pending;
  assign core_irq_req = gie && (|pending) && (state == ST_IDLE);

  // The core drops its global enable when it accepts a request
  always_comb begin
    next_gie = gie;
    if (global_irq_enable_op) begin
      next_gie = 1'b1;
    end
    if (global_irq_disable_op || (core_accept && core_irq_req)) begin
      next_gie = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Vector selection
  // --------------------------------------------------------------------
  // Sources ranked above the accepted one
  assign higher = ~src_vec_t'((acc_bits << 1) - 6'h01) &
                  ~acc_bits;

  always_comb begin
    next_state        = state;
    next_acc_bits     = acc_bits;
    next_late_vec     = late_vec;
    next_vector_addr  = vector_addr;
    next_vector_valid = 1'b0;
    case (state)
      ST_IDLE: begin
        if (core_accept && core_irq_req) begin
          next_acc_bits = prio_onehot(pending);
          next_late_vec = `VEC_NONE;
          next_state    = ST_ACCEPT;
        end
      end
      ST_ACCEPT: begin
        // A higher request in the accept-to-fetch gap corrupts the
        // address; software must check its flag after the branch
        next_late_vec = late_vec |
                        prio_vec(set_evt & mask & higher);
        if (core_vec_fetch) begin
          next_vector_addr  = prio_vec(acc_bits) | next_late_vec;
          next_vector_valid = 1'b1;
          next_state        = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag            <= `FLAG_RST;
      mask            <= `MASK_RST;
      ctrl            <= `CTRL_RST;
      gie             <= 1'b0;
      prdata          <= 32'h0000_0000;
      clock_timer_rst <= 1'b0;
      kport_q         <= 2'h0;
      state           <= ST_IDLE;
      acc_bits        <= 6'h00;
      late_vec        <= `VEC_NONE;
      vector_addr     <= `VEC_NONE;
      vector_valid    <= 1'b0;
    end else begin
      flag            <= next_flag;
      mask            <= next_mask;
      ctrl            <= next_ctrl;
      gie             <= next_gie;
      prdata          <= next_prdata;
      clock_timer_rst <= next_ctimer_rst;
      kport_q         <= next_kport_q;
      state           <= next_state;
      acc_bits        <= next_acc_bits;
      late_vec        <= next_late_vec;
      vector_addr     <= next_vector_addr;
      vector_valid    <= next_vector_valid;
    end
  end

endmodule : vectored_interrupt_flag_logic

// >>> irq_flag_regs.svh
`ifndef IRQ_FLAG_REGS_SVH
`define IRQ_FLAG_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_FLAG      12'h000
`define OFS_MASK      12'h004
`define OFS_CTRL      12'h008
`define OFS_STAT      12'h00c
`define OFS_VEC       12'h010

// ----------------------------------------------------------------------
// Event source bit positions, lowest priority first
// ----------------------------------------------------------------------
`define SRC_CTIMER    0
`define SRC_SWATCH    1
`define SRC_KPORT0    2
`define SRC_KPORT1    3
`define SRC_SERIAL    4
`define SRC_PTIMER    5
`define NUM_SRC       6

// ----------------------------------------------------------------------
// Vector addresses per source
// ----------------------------------------------------------------------
`define VEC_CTIMER    12'h102
`define VEC_SWATCH    12'h104
`define VEC_KPORT0    12'h106
`define VEC_KPORT1    12'h108
`define VEC_SERIAL    12'h10a
`define VEC_PTIMER    12'h10c
`define VEC_NONE      12'h000

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define CTRL_POL0     0
`define CTRL_POL1     1
`define CTRL_CTRST    2
`define CTRL_W        3
`define STAT_GIE      0
`define STAT_REQ      1
`define STAT_BUSY     2
`define MASK_RST      6'h00
`define CTRL_RST      3'h0
`define FLAG_RST      6'h00

`endif

// >>> irq_flag_pkg.sv
package irq_flag_pkg;

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ACCEPT = 1'b1
  } vec_state_t;

  typedef logic [5:0]  src_vec_t;
  typedef logic [11:0] pc_addr_t;

endpackage : irq_flag_pkg

// >>> pin_sync2.sv
module pin_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Asynchronous pins and their synchronised copy
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      pin_sync <= '0;
    end else begin
      stage1   <= pin_async;
      pin_sync <= stage1;
    end
  end

endmodule : pin_sync2

// >>> irq_flag_checker.sv
`include "irq_flag_regs.svh"

module irq_flag_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  // Core side
  input wire logic        core_accept,
  input wire logic        core_vec_fetch,
  input wire logic        core_irq_req,
  input wire logic [11:0] vector_addr,
  input wire logic        vector_valid,
  // Peripheral and system
  input wire logic        clock_timer_rst,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_req_gated: assert property (core_irq_req |-> irq)
    else $error("core request without pending interrupt");
  a_req_drop: assert property (core_accept && core_irq_req |=>
    !core_irq_req)
    else $error("core request stays after accept");
  a_fetch_answer: assert property (core_vec_fetch |=> vector_valid)
    else $error("no vector after fetch");
  a_valid_cause: assert property (vector_valid |->
    $past(core_vec_fetch) ##1 !vector_valid)
    else $error("vector valid without fetch or too long");
  a_vec_hold: assert property ($changed(vector_addr) |-> vector_valid)
    else $error("vector changed outside fetch answer");
  a_vec_range: assert property (vector_valid |->
    vector_addr[11:4] == 8'h10 && !vector_addr[0])
    else $error("vector outside table");
  a_ctrst_pulse: assert property (psel && penable && pwrite &&
    paddr == `OFS_CTRL && pwdata[`CTRL_CTRST] |=>
    clock_timer_rst ##1 !clock_timer_rst)
    else $error("clock timer reset pulse wrong");
  a_ctrst_cause: assert property (clock_timer_rst |->
    $past(psel && penable && pwrite))
    else $error("clock timer reset without write");
  a_bad_addr: assert property (psel && penable && paddr > `OFS_VEC |->
    pslverr)
    else $error("unmapped access not refused");

  cover property (core_accept);
  cover property (vector_valid && vector_addr == 12'h10e);
  cover property (clock_timer_rst);
  cover property (pslverr);
endmodule : irq_flag_checker

// >>> core_model.sv
module core_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench controls
  input  wire logic        irq_on_req,
  input  wire logic        irq_off_req,
  input  wire logic [3:0]  fetch_gap,
  // Block side
  input  wire logic        core_irq_req,
  input  wire logic        vector_valid,
  input  wire logic [11:0] vector_addr,
  output logic             global_irq_enable_op,
  output logic             global_irq_disable_op,
  output logic             core_accept,
  output logic             core_vec_fetch,
  // Observation
  output logic             busy,
  output logic [11:0]      last_vec,
  output logic [7:0]       vec_count
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt;
  logic       wait_v;

  // A long fetch gap opens the window for a late higher request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {global_irq_enable_op, global_irq_disable_op} <= 2'h0;
      {core_accept, core_vec_fetch, busy, wait_v} <= 4'h0;
      cnt <= 4'h0;
      last_vec <= 12'h000;
      vec_count <= 8'h00;
    end else begin
      global_irq_enable_op <= irq_on_req;
      global_irq_disable_op <= irq_off_req;
      core_accept <= 1'b0;
      core_vec_fetch <= 1'b0;
      if (!busy && core_irq_req && !core_accept) begin
        core_accept <= 1'b1;
        busy <= 1'b1;
        cnt <= fetch_gap;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy && !wait_v) begin
        core_vec_fetch <= 1'b1;
        wait_v <= 1'b1;
      end
      if (vector_valid && wait_v) begin
        last_vec <= vector_addr;
        vec_count <= vec_count + 8'h01;
        busy <= 1'b0;
        wait_v <= 1'b0;
      end
    end
  end
endmodule : core_model

// >>> test_vectored_interrupt_flag_logic.sv
`include "irq_flag_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end

module test_vectored_interrupt_flag_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, irq_on_req = 1'b0, irq_off_req = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] evt = 4'h0, fetch_gap = 4'h1;
  logic [1:0] kp = 2'h3;
  logic [31:0] prdata;
  logic [11:0] vector_addr, last_vec;
  logic [7:0] vec_count;
  logic pready, pslverr, core_accept, core_vec_fetch, core_irq_req;
  logic vector_valid, clock_timer_rst, irq, busy;
  logic global_irq_enable_op, global_irq_disable_op;
  int miscompares = 0, cmp_count = 0, cycles = 0;

  vectored_interrupt_flag_logic vectored_interrupt_flag_logic_i (.*,
    .clock_timer_evt(evt[0]), .stopwatch_evt(evt[1]),
    .serial_evt(evt[2]), .prog_timer_evt(evt[3]),
    .k_pin0(kp[0]), .k_pin1(kp[1]));
  core_model core_model_i (.*);

  always #50 pclk = ~pclk;

  task close_out;
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  // ----
  // Bus and stimulus helpers
  // ----
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task pulse(input logic [3:0] e, input logic en);
    @(posedge pclk);
    {evt, irq_on_req} <= {e, en};
    @(posedge pclk);
    {evt, irq_on_req} <= 5'h00;
  endtask : pulse

  task irq_off;
    @(posedge pclk);
    irq_off_req <= 1'b1;
    @(posedge pclk);
    irq_off_req <= 1'b0;
  endtask : irq_off

  task wait_vec(input logic [7:0] n);
    repeat (50) if (vec_count !== n) @(posedge pclk);
  endtask : wait_vec

  // Flags are read and the mask written with the core interrupt off
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK("reset reg", 32'h0, rd)
    end
    apb(1'b1, 12'h014, 32'hffffffff);
    `CHK("bad slverr", 1'b1, err)
    apb(1'b0, `OFS_MASK, 32'h0);
    `CHK("mask kept", 32'h0, rd)
    pulse(4'hf, 1'b0);
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("flag unmasked", 32'h33, rd)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("flag cleared", 32'h0, rd)
    kp <= 2'h2;
    repeat (5) @(posedge pclk);
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("port flag masked", 32'h0, rd)
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, `OFS_MASK, 32'h0);
      apb(1'b1, `OFS_MASK, 32'h4);
      repeat (4) @(posedge pclk);
      `CHK("port irq", 1'b1, irq)
      apb(1'b0, `OFS_FLAG, 32'h0);
      `CHK("port flag again", 32'h4, rd)
    end
    apb(1'b1, `OFS_MASK, 32'h0);
    kp <= 2'h3;
    apb(1'b1, `OFS_CTRL, 32'h4);
    repeat (2) @(posedge pclk);
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("timer reset flag", 32'h1, rd)
    apb(1'b1, `OFS_MASK, 32'h3f);
    pulse(4'h6, 1'b0);
    apb(1'b0, `OFS_STAT, 32'h0);
    `CHK("no req while off", 32'h0, rd)
    `CHK("irq pending", 1'b1, irq)
    pulse(4'h0, 1'b1);
    wait_vec(8'h01);
    `CHK("coinciding vector", 12'h10a, last_vec)
    irq_off();
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("handler flags", 32'h12, rd)
    // Late higher request lands between accept and fetch
    fetch_gap <= 4'h8;
    pulse(4'h1, 1'b0);
    pulse(4'h0, 1'b1);
    repeat (20) if (busy !== 1'b1) @(posedge pclk);
    pulse(4'h8, 1'b0);
    apb(1'b0, `OFS_STAT, 32'h0);
    `CHK("busy in gap", 32'h4, rd)
    wait_vec(8'h02);
    `CHK("diverted vector", 12'h10e, last_vec)
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("diverted flags", 32'h21, rd)
    apb(1'b0, `OFS_VEC, 32'h0);
    `CHK("vector reg", 32'h10e, rd)
    // Enable with nothing pending: the request must stay low
    pulse(4'h0, 1'b1);
    repeat (3) @(posedge pclk);
    apb(1'b0, `OFS_STAT, 32'h0);
    `CHK("enabled idle", 32'h1, rd)
    irq_off();
    // Port 1 active high: polarity change sees the level, then an edge
    apb(1'b1, `OFS_CTRL, 32'h2);
    repeat (4) @(posedge pclk);
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("port1 level", 32'h8, rd)
    kp <= 2'h1;
    repeat (4) @(posedge pclk);
    kp <= 2'h3;
    repeat (4) @(posedge pclk);
    `CHK("port1 edge", 1'b1, irq)
    apb(1'b1, `OFS_FLAG, 32'h8);
    apb(1'b0, `OFS_FLAG, 32'h0);
    `CHK("flag write clear", 32'h0, rd)
    close_out();
  end
endmodule : test_vectored_interrupt_flag_logic

bind vectored_interrupt_flag_logic irq_flag_checker irq_flag_checker_i (.*);
